// >>> design/cst_can_map.vh
// register offsets, field positions, reset values and limits of the can status block
`ifndef CST_CAN_MAP_VH
`define CST_CAN_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define CST_OFF_FLAGS      8'h00
`define CST_OFF_ENABLES    8'h04
`define CST_OFF_ERRCNT     8'h08
`define CST_OFF_CFG_ONE    8'h0c
`define CST_OFF_CFG_TWO    8'h10

// ----------------------------------------------------------------------------
// flag and status bit positions
// ----------------------------------------------------------------------------
`define CST_B_TX_BUS_OFF   13
`define CST_B_TX_PASSIVE   12
`define CST_B_RX_PASSIVE   11
`define CST_B_TX_WARNING   10
`define CST_B_RX_WARNING   9
`define CST_B_ANY_WARNING  8
`define CST_B_INVALID      7
`define CST_B_WAKE         6
`define CST_B_ERROR        5
`define CST_B_FIFO_AF      3
`define CST_B_RX_OVF       2
`define CST_B_RX_BUF       1
`define CST_B_TX_BUF       0

// ----------------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------------
`define CST_IRQ_MASK       8'hef
`define CST_CFG_ONE_MASK   16'h00ff
`define CST_CFG_TWO_MASK   16'h47ff
`define CST_EN_RST         8'h00
`define CST_CFG_ONE_RST    16'h0000
`define CST_CFG_TWO_RST    16'h0000

// ----------------------------------------------------------------------------
// configuration field positions
// ----------------------------------------------------------------------------
`define CST_JW_MSB         7
`define CST_JW_LSB         6
`define CST_QP_MSB         5
`define CST_QP_LSB         0
`define CST_WAKE_SEL_B     14
`define CST_PH2_MSB        10
`define CST_PH2_LSB        8
`define CST_PH2_MODE_B     7
`define CST_TRIPLE_B       6
`define CST_PH1_MSB        5
`define CST_PH1_LSB        3
`define CST_PROP_MSB       2
`define CST_PROP_LSB       0

// ----------------------------------------------------------------------------
// error counter limits and steps, automatic phase two minimum and wake filter count
// ----------------------------------------------------------------------------
`define CST_WARN_LIMIT     8'h60
`define CST_PASSIVE_LIMIT  8'h80
`define CST_TX_ERR_STEP    8'h08
`define CST_IPT_TQ         4'h2
`define CST_WAKE_FILT_CNT  8'h10

`endif

// >>> design/cst_glitch_filter.v
// glitch filter that passes a level only after it has been stable for a set count
`timescale 1ns/10ps
module cst_glitch_filter #(
    parameter       CW     = 8,
    parameter [7:0] STABLE = 8'h10
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          ce,
    input  wire          bypass,
    input  wire          din,
    output reg           dout,
    output reg           fall_pulse
);

    reg [CW-1:0] cnt_q;
    reg          cand_q;
    reg          dnext;

    // ------------------------------------------------------------------------
    // stability counter
    // ------------------------------------------------------------------------
    always @* begin
        dnext = dout;
        if (bypass)
            dnext = din;
        else if (din == cand_q && cnt_q == STABLE[CW-1:0])
            dnext = cand_q;
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q      <= {CW{1'b0}};
            cand_q     <= 1'b1;
            dout       <= 1'b1;
            fall_pulse <= 1'b0;
        end else if (ce) begin
            cand_q <= din;
            if (din != cand_q)
                cnt_q <= {CW{1'b0}};
            else if (cnt_q != STABLE[CW-1:0])
                cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            dout       <= dnext;
            // a dominant level after recessive counts as bus activity
            fall_pulse <= dout & ~dnext;
        end
    end

endmodule // cst_glitch_filter

// >>> design/cst_can_status.v
// can status flags, interrupt gating, error counters and bit timing behind an apb slave
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
`include "cst_can_map.vh"

// Functional notes
// R01: bit 13 reads one while transmitter bus-off
// R02: bits 12..8 passive and warning from counters
// R03: fifo almost-full flag bit 3 records request
// R04: flags clear by writing zero, one ignored
// R05: error flag sets on status bit rising
// R06: enable bit 6 gates wake-up request
// R07: enable 5 gates error, 3 fifo
// R08: enable bit 2 gates receive overflow
// R09: enable bit 1 gates receive buffer
// R10: enable bit 0 gates transmit; 15..8 zero
// R11: transmit error count in bits 15..8
// R12: receive error count in bits 7..0
// R13: jump width is field plus one quanta
// R14: quantum is two times prescaler plus one
// R15: phase two is field plus one quanta
// R16: phase two mode selects field or maximum
// R17: triple sampling selects three samples, else one
// R18: phase one is field plus one quanta
// R19: propagation field plus one; wake filter select
module cst_can_status #(
    parameter       FILT_W = 8,
    parameter [7:0] FILT_N = `CST_WAKE_FILT_CNT,
    parameter [3:0] IPT_TQ = `CST_IPT_TQ
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        tx_buf_evt,
    input  wire        rx_buf_evt,
    input  wire        rx_ovf_evt,
    input  wire        fifo_af_evt,
    input  wire        invalid_msg_evt,
    input  wire        tx_err_evt,
    input  wire        tx_ok_evt,
    input  wire        rx_err_evt,
    input  wire        rx_ok_evt,
    input  wire        rx_line,
    output reg         irq_req,
    output reg         tq_tick,
    output reg         sample_pulse,
    output reg         bit_start,
    output reg         rx_bit,
    output wire        wake_line
);

    // ------------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------------
    function [3:0] fn_len;
        input [2:0] code;
        begin
            fn_len = {1'b0, code} + 4'h1;
        end
    endfunction

    function fn_maj;
        input [2:0] s;
        begin
            fn_maj = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
        end
    endfunction

    function [3:0] fn_min;
        input [3:0] a;
        input [3:0] b;
        begin
            fn_min = (a < b) ? a : b;
        end
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    localparam [3:0] ST_SYNC = 4'b0001;
    localparam [3:0] ST_PROP = 4'b0010;
    localparam [3:0] ST_PH1  = 4'b0100;
    localparam [3:0] ST_PH2  = 4'b1000;

    reg  [7:0]  flags_q;
    reg  [7:0]  flags_d;
    reg  [7:0]  en_q;
    reg  [7:0]  tec_q;
    reg  [7:0]  rec_q;
    reg         bus_off_q;
    reg  [5:0]  stat_prev_q;
    reg  [15:0] cfg1_q;
    reg  [15:0] cfg2_q;
    reg  [6:0]  pcnt_q;
    reg  [3:0]  st_q;
    reg  [3:0]  qcnt_q;
    reg  [3:0]  ext_q;
    reg  [3:0]  sht_q;
    reg         resync_done_q;
    reg         edge_pend_q;
    reg         line_prev_q;
    reg  [1:0]  samp_sr_q;
    reg  [31:0] rd_val;
    reg         rd_err;
    reg  [7:0]  set_v;
    reg  [7:0]  clr_v;

    wire [5:0]  stat_w;
    wire        wake_pulse;
    wire        setup_ph = psel & ~penable;
    wire        wr_acc   = psel & penable & pready & pwrite;
    wire        tq       = (pcnt_q == {cfg1_q[`CST_QP_MSB:`CST_QP_LSB], 1'b1}); // R14
    wire [3:0]  sjw1     = fn_len({1'b0, cfg1_q[`CST_JW_MSB:`CST_JW_LSB]}); // R13
    wire [3:0]  prop_len = fn_len(cfg2_q[`CST_PROP_MSB:`CST_PROP_LSB]); // R19
    wire [3:0]  ph1_len  = fn_len(cfg2_q[`CST_PH1_MSB:`CST_PH1_LSB]); // R18
    wire [3:0]  ph2_prog = fn_len(cfg2_q[`CST_PH2_MSB:`CST_PH2_LSB]); // R15
    wire [3:0]  ph2_auto = (ph1_len > IPT_TQ) ? ph1_len : IPT_TQ;
    wire [3:0]  ph2_len  = cfg2_q[`CST_PH2_MODE_B] ? ph2_prog : ph2_auto; // R16
    wire [3:0]  ph1_end  = ph1_len + ext_q;
    wire [3:0]  ph2_end  = ph2_len - sht_q;
    wire [3:0]  ph2_left = ph2_len - qcnt_q;
    wire        edge_now = line_prev_q & ~rx_line;

    // ------------------------------------------------------------------------
    // error state derived from the counters
    // ------------------------------------------------------------------------
    assign stat_w[5] = bus_off_q; // R01
    assign stat_w[4] = tec_q >= `CST_PASSIVE_LIMIT; // R02
    assign stat_w[3] = rec_q >= `CST_PASSIVE_LIMIT; // R02
    assign stat_w[2] = tec_q >= `CST_WARN_LIMIT; // R02
    assign stat_w[1] = rec_q >= `CST_WARN_LIMIT; // R02
    assign stat_w[0] = stat_w[2] | stat_w[1]; // R02

    // ------------------------------------------------------------------------
    // wake-up line filter
    // ------------------------------------------------------------------------
    // the filter only delays the wake view; the timing logic uses the raw line
    cst_glitch_filter #(
        .CW     (FILT_W),
        .STABLE (FILT_N)
    ) u_wake_filt (
        .clk        (pclk),
        .rst_n      (presetn),
        .ce         (ce),
        .bypass     (~cfg2_q[`CST_WAKE_SEL_B]), // R19
        .din        (rx_line),
        .dout       (wake_line),
        .fall_pulse (wake_pulse)
    );

    // ------------------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------------------
    always @* begin
        set_v                = 8'h00;
        set_v[`CST_B_TX_BUF] = tx_buf_evt;
        set_v[`CST_B_RX_BUF] = rx_buf_evt;
        set_v[`CST_B_RX_OVF] = rx_ovf_evt;
        set_v[`CST_B_FIFO_AF] = fifo_af_evt; // R03
        set_v[`CST_B_ERROR]  = |(stat_w & ~stat_prev_q); // R05
        set_v[`CST_B_WAKE]   = wake_pulse;
        set_v[`CST_B_INVALID] = invalid_msg_evt;
        clr_v = 8'h00;
        if (wr_acc && paddr == `CST_OFF_FLAGS)
            clr_v = ~pwdata[7:0] & `CST_IRQ_MASK; // R04
        // a new event beats a clear in the same cycle
        flags_d = ((flags_q & ~clr_v) | set_v) & `CST_IRQ_MASK; // R04
    end

    // ------------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------------
    always @* begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        case (paddr)
            `CST_OFF_FLAGS:   rd_val = {18'h00000, stat_w, flags_q};
            `CST_OFF_ENABLES: rd_val = {24'h000000, en_q}; // R10
            `CST_OFF_ERRCNT:  rd_val = {16'h0000, tec_q, rec_q}; // R11 R12
            `CST_OFF_CFG_ONE: rd_val = {16'h0000, cfg1_q};
            `CST_OFF_CFG_TWO: rd_val = {16'h0000, cfg2_q};
            default:          rd_err = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------------
    // apb slave and registers
    // ------------------------------------------------------------------------
    // one wait-free access phase; read data is captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata      <= 32'h0000_0000;
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            flags_q     <= 8'h00;
            en_q        <= `CST_EN_RST;
            cfg1_q      <= `CST_CFG_ONE_RST;
            cfg2_q      <= `CST_CFG_TWO_RST;
            stat_prev_q <= 6'h00;
            irq_req     <= 1'b0;
        end else if (ce) begin
            pready  <= setup_ph;
            pslverr <= setup_ph & rd_err;
            if (setup_ph)
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
            flags_q     <= flags_d;
            stat_prev_q <= stat_w; // R05
            if (wr_acc) begin
                case (paddr)
                    `CST_OFF_ENABLES: en_q   <= pwdata[7:0] & `CST_IRQ_MASK; // R10
                    `CST_OFF_CFG_ONE: cfg1_q <= pwdata[15:0] & `CST_CFG_ONE_MASK;
                    `CST_OFF_CFG_TWO: cfg2_q <= pwdata[15:0] & `CST_CFG_TWO_MASK;
                    default:          cfg1_q <= cfg1_q;
                endcase
            end
            // each source reaches the request only through its enable bit
            irq_req <= |(flags_q & en_q); // R06 R07 R08 R09 R10
        end
    end

    // ------------------------------------------------------------------------
    // error counters
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tec_q     <= 8'h00; // R11
            rec_q     <= 8'h00; // R12
            bus_off_q <= 1'b0;
        end else if (ce) begin
            if (tx_err_evt) begin
                // overflow past the top of the counter means bus-off
                if (tec_q > 8'hff - `CST_TX_ERR_STEP) begin
                    tec_q     <= 8'hff;
                    bus_off_q <= 1'b1; // R01
                end else begin
                    tec_q <= tec_q + `CST_TX_ERR_STEP; // R11
                end
            end else if (tx_ok_evt && tec_q != 8'h00 && !bus_off_q) begin
                tec_q <= tec_q - 8'h01;
            end
            if (rx_err_evt && rec_q != 8'hff)
                rec_q <= rec_q + 8'h01; // R12
            else if (rx_ok_evt && rec_q != 8'h00)
                rec_q <= rec_q - 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // quantum prescaler
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcnt_q  <= 7'h00;
            tq_tick <= 1'b0;
        end else if (ce) begin
            pcnt_q  <= tq ? 7'h00 : pcnt_q + 7'h01; // R14
            tq_tick <= tq;
        end
    end

    // ------------------------------------------------------------------------
    // bit segment sequencer with resynchronisation
    // ------------------------------------------------------------------------
    // only one resync per bit; hard sync on idle bus is left to the protocol engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q          <= ST_SYNC;
            qcnt_q        <= 4'h0;
            ext_q         <= 4'h0;
            sht_q         <= 4'h0;
            resync_done_q <= 1'b0;
            edge_pend_q   <= 1'b0;
            line_prev_q   <= 1'b1;
            samp_sr_q     <= 2'b11;
            sample_pulse  <= 1'b0;
            bit_start     <= 1'b0;
            rx_bit        <= 1'b1;
        end else if (ce) begin
            line_prev_q  <= rx_line;
            sample_pulse <= 1'b0;
            bit_start    <= 1'b0;
            if (edge_now)
                edge_pend_q <= 1'b1;
            if (tq) begin
                edge_pend_q <= 1'b0;
                samp_sr_q   <= {samp_sr_q[0], rx_line};
                case (st_q)
                    ST_SYNC: begin
                        st_q   <= ST_PROP;
                        qcnt_q <= 4'h0;
                    end
                    ST_PROP: begin
                        if (edge_pend_q && !resync_done_q) begin
                            ext_q         <= fn_min(qcnt_q + 4'h1, sjw1); // R13
                            resync_done_q <= 1'b1;
                        end
                        if (qcnt_q + 4'h1 == prop_len) begin // R19
                            st_q   <= ST_PH1;
                            qcnt_q <= 4'h0;
                        end else begin
                            qcnt_q <= qcnt_q + 4'h1;
                        end
                    end
                    ST_PH1: begin
                        if (edge_pend_q && !resync_done_q) begin
                            ext_q         <= fn_min(prop_len + qcnt_q + 4'h1, sjw1); // R13
                            resync_done_q <= 1'b1;
                        end
                        if (qcnt_q + 4'h1 >= ph1_end) begin // R18
                            st_q         <= ST_PH2;
                            qcnt_q       <= 4'h0;
                            sample_pulse <= 1'b1;
                            rx_bit       <= cfg2_q[`CST_TRIPLE_B] ? fn_maj({samp_sr_q, rx_line}) : rx_line; // R17
                        end else begin
                            qcnt_q <= qcnt_q + 4'h1;
                        end
                    end
                    ST_PH2: begin
                        if (edge_pend_q && !resync_done_q && ph2_left <= sjw1) begin
                            // the edge quantum becomes the sync segment of the next bit
                            st_q          <= ST_PROP; // R13
                            qcnt_q        <= 4'h0;
                            ext_q         <= 4'h0;
                            sht_q         <= 4'h0;
                            resync_done_q <= 1'b0;
                            bit_start     <= 1'b1;
                        end else if (edge_pend_q && !resync_done_q) begin
                            sht_q         <= sjw1; // R13
                            resync_done_q <= 1'b1;
                            qcnt_q        <= qcnt_q + 4'h1;
                        end else if (qcnt_q + 4'h1 >= ph2_end) begin // R15 R16
                            st_q          <= ST_SYNC;
                            qcnt_q        <= 4'h0;
                            ext_q         <= 4'h0;
                            sht_q         <= 4'h0;
                            resync_done_q <= 1'b0;
                            bit_start     <= 1'b1;
                        end else begin
                            qcnt_q <= qcnt_q + 4'h1;
                        end
                    end
                    default: begin
                        st_q   <= ST_SYNC;
                        qcnt_q <= 4'h0;
                    end
                endcase
            end
        end
    end

endmodule // cst_can_status

// >>> dv/cst_bus_node.sv
// far-side bus node that pulls the receive line dominant on command
`timescale 1ns/10ps
module cst_bus_node (
    input  wire       clk,
    input  wire       go,
    input  wire [7:0] len,
    output reg        line
);
    reg [7:0] cnt_q;
    initial begin
        line = 1'b1;
        cnt_q = 8'h00;
    end
    // the transceiver pull-up returns the line to recessive once released
    always @(posedge clk) begin
        if (go) begin
            line <= 1'b0;
            cnt_q <= len;
        end else if (cnt_q > 8'h01) begin
            cnt_q <= cnt_q - 8'h01;
        end else begin
            line <= 1'b1;
            cnt_q <= 8'h00;
        end
    end
endmodule // cst_bus_node

// >>> dv/cst_can_status_checker.sv
// port-level assertions for the can status block
`timescale 1ns/10ps
`include "cst_can_map.vh"
module cst_can_status_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        tx_err_evt,
    input wire        tx_ok_evt,
    input wire        rx_err_evt,
    input wire        rx_ok_evt,
    input wire        rx_line,
    input wire        irq_req,
    input wire        tq_tick,
    input wire        wake_line
);
    reg  [7:0] tec_q, rec_q, en_q;
    reg        off_q, wsel_q;
    wire       wr = psel && penable && pready && pwrite && ce;
    // shadow counters; bus-off freezes the decrement until reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tec_q <= 8'h00;
            rec_q <= 8'h00;
            en_q <= 8'h00;
            off_q <= 1'b0;
            wsel_q <= 1'b0;
        end else if (ce) begin
            if (tx_err_evt) begin
                tec_q <= (tec_q > 8'hf7) ? 8'hff : tec_q + 8'h08;
                off_q <= off_q || (tec_q > 8'hf7);
            end else if (tx_ok_evt && tec_q != 8'h00 && !off_q) begin
                tec_q <= tec_q - 8'h01;
            end
            if (rx_err_evt) begin
                rec_q <= (rec_q == 8'hff) ? 8'hff : rec_q + 8'h01;
            end else if (rx_ok_evt && rec_q != 8'h00) begin
                rec_q <= rec_q - 8'h01;
            end
            if (wr && paddr == `CST_OFF_ENABLES) en_q <= pwdata[7:0] & `CST_IRQ_MASK;
            if (wr && paddr == `CST_OFF_CFG_TWO) wsel_q <= pwdata[14];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_rd_cnt;
        s_setup ##1 (penable && !pwrite && paddr == `CST_OFF_ERRCNT);
    endsequence
    a_ready_next: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_pulse: assert property (pready && ce |=> !pready) else $error("ready held");
    a_unmapped_err: assert property (pready |-> pslverr == !(paddr inside {`CST_OFF_FLAGS,
        `CST_OFF_ENABLES, `CST_OFF_ERRCNT, `CST_OFF_CFG_ONE, `CST_OFF_CFG_TWO})) else $error("bad slave error");
    a_tec_read: assert property (s_rd_cnt |-> prdata[31:8] == {16'h0000, $past(tec_q)})
        else $error("tx count read wrong");
    a_rec_read: assert property (s_rd_cnt |-> prdata[7:0] == $past(rec_q))
        else $error("rx count read wrong");
    a_irq_masked: assert property (en_q == 8'h00 && ce |=> !irq_req) else $error("masked irq");
    a_tq_gap: assert property (tq_tick && ce |=> !tq_tick) else $error("quantum too short");
    a_wake_follow: assert property (!wsel_q && ce |=> wake_line == $past(rx_line))
        else $error("wake line not following");
    a_wake_stable: assert property ($past(wsel_q) && $changed(wake_line) |-> $past(rx_line, 2) == wake_line)
        else $error("wake glitch passed");
endmodule // cst_can_status_checker

bind cst_can_status cst_can_status_checker u_chk (.*);

// >>> dv/cst_can_status_tb.sv
// self-checking bench for the can status block
`timescale 1ns/10ps
`include "cst_can_map.vh"
module cst_can_status_tb;
    reg         pclk, presetn, ce, psel, penable, pwrite, go, er;
    reg  [7:0]  paddr, len;
    reg  [8:0]  evt;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, irq_req, tq_tick, sample_pulse, bit_start, rx_bit, wake_line, rx_line;
    int         n_errors, num_checks, cyc, n, i, c1, c2, et, p2e;
    int         bpos[5] = '{0, 1, 2, 3, 7};
    int         qp[4] = '{0, 63, 1, 2};
    int         pr[4] = '{0, 7, 2, 1};
    int         p1[4] = '{0, 7, 0, 4};
    int         p2[4] = '{0, 7, 5, 0};
    int         md[4] = '{1, 1, 0, 0};
    // filter count shortened so wake tests stay brief
    cst_can_status #(.FILT_N(8'h02)) u_dut (.*, .tx_buf_evt(evt[0]), .rx_buf_evt(evt[1]), .rx_ovf_evt(evt[2]),
        .fifo_af_evt(evt[3]), .invalid_msg_evt(evt[4]), .tx_err_evt(evt[5]), .tx_ok_evt(evt[6]),
        .rx_err_evt(evt[7]), .rx_ok_evt(evt[8]));
    cst_bus_node u_node (.clk(pclk), .line(rx_line), .*);
    always #10 pclk = ~pclk;
    // ----
    // tasks
    // ----
    task end_of_test;
        if (n_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rchk(input [7:0] a, input [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task ev(input int k, input int c);
        repeat (c) begin
            @(posedge pclk);
            evt[k] <= 1'b1;
            @(posedge pclk);
            evt[k] <= 1'b0;
        end
    endtask
    task dom(input [7:0] l);
        @(posedge pclk);
        go <= 1'b1;
        len <= l;
        @(posedge pclk);
        go <= 1'b0;
    endtask
    task span(input bit b, output int g);
        g = 0;
        do @(posedge pclk); while ((b ? bit_start : tq_tick) !== 1'b1);
        do begin
            @(posedge pclk);
            g++;
        end while ((b ? bit_start : tq_tick) !== 1'b1);
    endtask
    task smp;
        repeat (2) do @(posedge pclk); while (sample_pulse !== 1'b1);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            end_of_test;
        end
    end
    // ----
    // main sequence
    // ----
    initial begin
        {pclk, presetn, psel, penable, pwrite, go, paddr, len, evt, pwdata} = 0;
        ce = 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) rchk(i * 4, 32'h0);
        chk(wake_line, 1'b1);
        apb(8'h14, 1'b1, 32'h0);
        chk(er, 1'b1);
        apb(`CST_OFF_ENABLES, 1'b1, 32'hffffffff);
        rchk(`CST_OFF_ENABLES, 32'hef);
        apb(`CST_OFF_ERRCNT, 1'b1, 32'hffff);
        rchk(`CST_OFF_ERRCNT, 32'h0);
        for (i = 0; i < 5; i++) ev(i, 1);
        rchk(`CST_OFF_FLAGS, 32'h8f);
        apb(`CST_OFF_FLAGS, 1'b1, 32'hffff);
        rchk(`CST_OFF_FLAGS, 32'h8f);
        apb(`CST_OFF_FLAGS, 1'b1, 32'hfff7);
        rchk(`CST_OFF_FLAGS, 32'h87);
        apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        for (i = 0; i < 5; i++) begin
            apb(`CST_OFF_ENABLES, 1'b1, 32'h1 << bpos[i]);
            ev(i, 1);
            repeat (3) @(posedge pclk);
            chk(irq_req, 1'b1);
            apb(`CST_OFF_ENABLES, 1'b1, ~(32'h1 << bpos[i]));
            repeat (2) @(posedge pclk);
            chk(irq_req, 1'b0);
            apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        end
        apb(`CST_OFF_ENABLES, 1'b1, 32'h20);
        ev(7, 3);
        ev(8, 1);
        rchk(`CST_OFF_ERRCNT, 32'h2);
        ev(5, 12);
        rchk(`CST_OFF_ERRCNT, 32'h6002);
        rchk(`CST_OFF_FLAGS, 32'h520);
        chk(irq_req, 1'b1);
        apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        rchk(`CST_OFF_FLAGS, 32'h500);
        ev(7, 94);
        rchk(`CST_OFF_FLAGS, 32'h720);
        apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        ev(5, 4);
        ev(7, 32);
        rchk(`CST_OFF_FLAGS, 32'h1f20);
        ev(6, 1);
        ev(5, 17);
        ev(6, 1);
        rchk(`CST_OFF_ERRCNT, 32'hff80);
        apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        rchk(`CST_OFF_FLAGS, 32'h3f00);
        for (i = 0; i < 4; i++) begin
            c1 = (i << 6) | qp[i];
            c2 = (p2[i] << 8) | (md[i] << 7) | ((i == 3) << 6) | (p1[i] << 3) | pr[i];
            p2e = md[i] ? p2[i] + 1 : ((p1[i] + 1 > `CST_IPT_TQ) ? p1[i] + 1 : `CST_IPT_TQ);
            et = 2 * (qp[i] + 1);
            apb(`CST_OFF_CFG_ONE, 1'b1, c1);
            apb(`CST_OFF_CFG_TWO, 1'b1, c2);
            rchk(`CST_OFF_CFG_ONE, c1);
            rchk(`CST_OFF_CFG_TWO, c2);
            span(1'b0, n);
            chk(n, et);
            span(1'b1, n);
            span(1'b1, n);
            chk(n, et * (3 + pr[i] + p1[i] + p2e));
        end
        apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        dom(8'h01);
        repeat (4) @(posedge pclk);
        rchk(`CST_OFF_FLAGS, 32'h3f40);
        apb(`CST_OFF_ENABLES, 1'b1, 32'h40);
        repeat (2) @(posedge pclk);
        chk(irq_req, 1'b1);
        apb(`CST_OFF_ENABLES, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq_req, 1'b0);
        apb(`CST_OFF_CFG_TWO, 1'b1, 32'h4000 | c2);
        apb(`CST_OFF_FLAGS, 1'b1, 32'h0);
        dom(8'h01);
        repeat (6) @(posedge pclk);
        rchk(`CST_OFF_FLAGS, 32'h3f00);
        dom(8'hc8);
        smp;
        chk(rx_bit, 1'b0);
        repeat (200) @(posedge pclk);
        rchk(`CST_OFF_FLAGS, 32'h3f40);
        end_of_test;
    end
endmodule // cst_can_status_tb
